// >>> src/rtcsp_slave.sv
// Device end: two-wire slave port with 32-byte map
// Function
// - START plus address D0h selects device
// - 32 bytes reachable sequentially from zero
// - Bytes 0..7 hold the time counters
// - Trim, watchdog, alarms, flags, timer, RAM follow
// - Supply fail aborts access, clears pointer
// - Supply fail ignores all bus inputs
// - Transfers begin only on idle bus
// - SDA fall, SCL high is START
// - SDA rise, SCL high is STOP
// - SDA stable while SCL high
// - Eight bits then ninth acknowledge bit
// - No limit on bytes per transfer
// - Acknowledger holds SDA low whole pulse
// - Device acknowledges own address and each byte written
// - Master NACKs final read byte
// - After NACK device releases SDA
// - Write sets pointer; read continues from it
// - Pointer advances on data acknowledge clock
// - Snapshot time counters at access start
// - Write back time at end or past 7
`timescale 1ns/1ps
module rtcsp_slave
  import rtcsp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Two-wire bus
  rtcsp_bus_if.device      bus,
  // Supply fail
  input  wire logic        supply_fail,
  // Time counters
  input  wire logic [63:0] time_now,
  output logic [63:0]      time_load,
  output logic             time_load_en,
  // Byte map view of the other functions
  output logic [4:0]       map_addr,
  output logic [7:0]       map_wdata,
  output logic             map_we,
  input  wire logic [7:0]  map_rdata
);
  typedef enum logic [2:0] {
    RTCSP_IDLE  = 3'b000,
    RTCSP_ADDR  = 3'b001,
    RTCSP_WPTR  = 3'b010,
    RTCSP_WDATA = 3'b011,
    RTCSP_RDATA = 3'b100
  } rtcsp_state_t;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic scl_s;
  logic sda_s;
  logic fail_s;
  rtcsp_sync u_scl  (.sys_clk(sys_clk), .rstn(rstn), .pin(bus.scl),     .pin_s(scl_s));
  rtcsp_sync u_sda  (.sys_clk(sys_clk), .rstn(rstn), .pin(bus.sda),     .pin_s(sda_s));
  rtcsp_sync u_fail (.sys_clk(sys_clk), .rstn(rstn), .pin(~supply_fail), .pin_s(fail_s));
  wire fail = ~fail_s;

  // ----------------------------------------
  // Edge and condition detection
  // ----------------------------------------
  logic         scl_q;
  logic         sda_q;
  wire          scl_rise = scl_s & ~scl_q;
  wire          scl_fall = ~scl_s & scl_q;
  wire          start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire          stop_c   = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------
  // Transfer state
  // ----------------------------------------
  rtcsp_state_t st_q;
  logic [3:0]   bit_q;
  logic [7:0]   sh_q;
  logic [4:0]   ptr_q;
  logic [63:0]  hold_q;
  logic         wr_dirty_q;
  logic         ack_q;
  logic         mack_q;
  logic         drive_q;
  logic         drv_val_q;
  logic [63:0]  load_q;
  logic         load_en_q;
  logic         we_q;
  logic [7:0]   wdata_q;
  logic [4:0]   waddr_q;
  logic [1:0]   lead_q;

  wire          in_byte   = (st_q != RTCSP_IDLE);
  wire          byte_done = scl_rise & (bit_q == BIT_LAST);
  wire          ack_clk   = scl_fall & (bit_q == BIT_ACK);
  wire [7:0]    rx_byte   = {sh_q[6:0], sda_s};
  wire          addr_hit  = (rx_byte[7:1] == SLAVE_ADDR);
  wire [4:0]    ptr_inc   = (ptr_q == PTR_LAST) ? PTR_FIRST : ptr_q + 5'h01;
  wire          in_time   = (ptr_q <= TIME_LAST);
  wire [7:0]    rd_byte   = in_time ? hold_q[{ptr_q[2:0], 3'b000} +: 8] : map_rdata;
  wire          past_time = ack_clk & (st_q == RTCSP_WDATA) & (ptr_q == TIME_LAST);
  wire          end_write = wr_dirty_q & (stop_c | start_c | fail | past_time);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn || fail) begin
      st_q    <= RTCSP_IDLE;
      bit_q   <= 4'h0;
      ptr_q   <= PTR_FIRST;
      drive_q <= 1'b0;
      ack_q   <= 1'b0;
      drv_val_q <= 1'b0;
      lead_q  <= 2'b00;
    end else if (start_c) begin
      st_q    <= RTCSP_ADDR;
      bit_q   <= 4'hF; // Skips the fall closing START
      drive_q <= 1'b0;
      lead_q  <= 2'b00;
    end else if (stop_c) begin
      st_q    <= RTCSP_IDLE;
      drive_q <= 1'b0;
      lead_q  <= 2'b00;
    end else if (in_byte) begin
      lead_q <= {lead_q[0], 1'b0};
      if (scl_rise && bit_q < BIT_ACK)
        sh_q <= rx_byte;
      if (scl_rise && bit_q == BIT_ACK)
        mack_q <= ~sda_s;
      if (byte_done)
        ack_q <= (st_q != RTCSP_RDATA) && ((st_q != RTCSP_ADDR) || addr_hit);
      if (scl_fall) begin
        bit_q <= (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
        // Next bit on SDA, set during SCL low
        if (bit_q == BIT_LAST) begin
          drive_q   <= ack_q;
          drv_val_q <= 1'b0;
        end else if (bit_q == BIT_ACK) begin
          unique case (st_q)
            RTCSP_ADDR: begin
              if (!ack_q) st_q <= RTCSP_IDLE;
              else if (sh_q[0]) st_q <= RTCSP_RDATA;
              else st_q <= RTCSP_WPTR;
            end
            RTCSP_WPTR: begin
              ptr_q <= sh_q[PTR_W-1:0];
              st_q  <= RTCSP_WDATA;
            end
            RTCSP_WDATA: ptr_q <= ptr_inc;
            RTCSP_RDATA: begin
              if (!mack_q) st_q <= RTCSP_IDLE;
            end
            default: st_q <= RTCSP_IDLE;
          endcase
          if (st_q == RTCSP_RDATA)
            ptr_q <= ptr_inc;
          drive_q <= 1'b0;
        end else begin
          drive_q <= 1'b0;
        end
        ack_q <= (bit_q == BIT_LAST) ? ack_q : 1'b0;
      end
      // Read data bits driven on the falls that open bits 1..7
      if (scl_fall && st_q == RTCSP_RDATA && bit_q < BIT_LAST) begin
        drive_q   <= ~rd_byte[3'(BIT_LAST - 4'(bit_q + 4'h1))];
        drv_val_q <= 1'b0;
      end
      if (scl_fall && bit_q == BIT_ACK &&
          ((st_q == RTCSP_ADDR && ack_q && sh_q[0]) || (st_q == RTCSP_RDATA && mack_q))) begin
        lead_q <= 2'b01;
      end
      // First read bit waits for new pointer at map_rdata
      if (lead_q[1]) begin
        drive_q   <= ~rd_byte[7];
        drv_val_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Time snapshot and write back
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hold_q     <= TIME_ZERO;
      wr_dirty_q <= 1'b0;
      load_q     <= TIME_ZERO;
      load_en_q  <= 1'b0;
      we_q       <= 1'b0;
      wdata_q    <= BYTE_ZERO;
      waddr_q    <= PTR_FIRST;
    end else begin
      load_en_q <= end_write;
      we_q      <= 1'b0;
      if (end_write) begin
        load_q     <= hold_q;
        wr_dirty_q <= 1'b0;
      end
      if (start_c && !fail)
        hold_q <= time_now;
      if (!fail && scl_rise && st_q == RTCSP_WDATA && bit_q == BIT_LAST) begin
        if (in_time) begin
          hold_q[{ptr_q[2:0], 3'b000} +: 8] <= rx_byte;
          wr_dirty_q <= 1'b1;
        end else begin
          we_q    <= 1'b1;
          wdata_q <= rx_byte;
          waddr_q <= ptr_q;
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      map_addr <= PTR_FIRST;
    end else begin
      map_addr <= we_q ? waddr_q : ptr_q;
    end
  end
  assign bus.sda_s_o   = drv_val_q;
  assign bus.sda_s_oe  = drive_q;
  assign time_load     = load_q;
  assign time_load_en  = load_en_q;
  assign map_wdata     = wdata_q;
  assign map_we        = we_q;
endmodule

// >>> src/rtcsp_pkg.sv
// Shared constants for the two-wire RTC slave port
package rtcsp_pkg;
  localparam int          MAP_DEPTH   = 32;
  localparam int          PTR_W       = 5;
  localparam logic [6:0]  SLAVE_ADDR  = 7'h68;
  localparam logic [4:0]  PTR_FIRST   = 5'h00;
  localparam logic [4:0]  PTR_LAST    = 5'h1F;
  localparam logic [4:0]  TIME_LAST   = 5'h07;
  localparam logic [3:0]  BIT_LAST    = 4'h7;
  localparam logic [3:0]  BIT_ACK     = 4'h8;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [63:0] TIME_ZERO   = 64'h0000_0000_0000_0000;
  localparam int          SYS_MHZ     = 250;
  localparam int          SCL_KHZ     = 400;
  localparam int          HALF_CYC    = (SYS_MHZ * 1000) / (SCL_KHZ * 4);
  localparam logic [9:0]  HALF_LAST   = 10'(HALF_CYC - 1);
  localparam logic [9:0]  HALF_ZERO   = 10'h000;
  localparam logic [1:0]  SYNC_IDLE   = 2'h3;
endpackage

// >>> src/rtcsp_bus_if.sv
// Two-wire bus between the master and the RTC slave port
`timescale 1ns/1ps
interface rtcsp_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  wire  scl = ~(scl_oe & ~scl_o);
  wire  sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface

// >>> src/rtcsp_sync.sv
// Two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module rtcsp_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Pin and result
  input  wire logic pin,
  output logic      pin_s
);
  logic meta_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_q <= 1'b1;
      pin_s  <= 1'b1;
    end else begin
      meta_q <= pin;
      pin_s  <= meta_q;
    end
  end
endmodule

// >>> src/rtcsp_master.sv
// Host end: two-wire bus master issuing byte commands
`timescale 1ns/1ps
module rtcsp_master
  import rtcsp_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Two-wire bus
  rtcsp_bus_if.host       bus,
  // Command port
  input  wire logic       cmd_valid,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_read,
  input  wire logic       cmd_nack,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_ready,
  output logic [7:0]      rsp_data,
  output logic            rsp_ack,
  output logic            rsp_valid
);
  typedef enum logic [2:0] {
    RTCSP_M_IDLE  = 3'b000,
    RTCSP_M_START = 3'b001,
    RTCSP_M_BITS  = 3'b010,
    RTCSP_M_STOP  = 3'b011,
    RTCSP_M_DONE  = 3'b100
  } rtcsp_mstate_t;

  logic          sda_s;
  rtcsp_sync u_sda (.sys_clk(sys_clk), .rstn(rstn), .pin(bus.sda), .pin_s(sda_s));

  rtcsp_mstate_t st_q;
  logic [9:0]    div_q;
  logic [1:0]    ph_q;
  logic [3:0]    bit_q;
  logic [7:0]    sh_q;
  logic          rd_q;
  logic          nack_q;
  logic          stop_q;
  logic          scl_q;
  logic          sda_q;
  logic          ack_q;
  logic          rv_q;
  wire           tick    = (div_q == HALF_LAST);
  wire           take    = (st_q == RTCSP_M_IDLE) & cmd_valid & cmd_ready;
  wire           tx_bit  = (bit_q == BIT_ACK) ? (rd_q ? nack_q : 1'b1) : (rd_q ? 1'b1 : sh_q[7]);

  // Phases: 0 low-setup, 1 rise, 2 high-sample, 3 fall
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_q   <= RTCSP_M_IDLE;
      div_q  <= HALF_ZERO;
      ph_q   <= 2'h0;
      bit_q  <= 4'h0;
      sh_q   <= BYTE_ZERO;
      rd_q   <= 1'b0;
      nack_q <= 1'b0;
      stop_q <= 1'b0;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      ack_q  <= 1'b0;
      rv_q   <= 1'b0;
    end else begin
      rv_q  <= 1'b0;
      div_q <= (st_q == RTCSP_M_IDLE || tick) ? HALF_ZERO : div_q + 10'h001;
      if (take) begin
        sh_q   <= cmd_data;
        rd_q   <= cmd_read;
        nack_q <= cmd_nack;
        stop_q <= cmd_stop;
        bit_q  <= 4'h0;
        ph_q   <= 2'h0;
        st_q <= cmd_start ? RTCSP_M_START : RTCSP_M_BITS;
      end else if (tick) begin
        ph_q <= ph_q + 2'h1;
        unique case (st_q)
          RTCSP_M_START: begin
            unique case (ph_q)
              2'h0: sda_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b0;
              2'h3: begin
                scl_q <= 1'b0;
                st_q  <= RTCSP_M_BITS;
              end
            endcase
          end
          RTCSP_M_BITS: begin
            unique case (ph_q)
              2'h0: sda_q <= tx_bit;
              2'h1: scl_q <= 1'b1;
              2'h2: begin
                if (bit_q == BIT_ACK) ack_q <= ~sda_s;
                else sh_q <= {sh_q[6:0], sda_s};
              end
              2'h3: begin
                scl_q <= 1'b0;
                bit_q <= bit_q + 4'h1;
                if (bit_q == BIT_ACK) begin
                  st_q <= stop_q ? RTCSP_M_STOP : RTCSP_M_DONE;
                end
              end
            endcase
          end
          RTCSP_M_STOP: begin
            unique case (ph_q)
              2'h0: sda_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_q <= 1'b1;
              2'h3: st_q <= RTCSP_M_DONE;
            endcase
          end
          default: begin
            rv_q <= 1'b1;
            st_q <= RTCSP_M_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cmd_ready <= 1'b0;
      rsp_data  <= BYTE_ZERO;
      rsp_ack   <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      cmd_ready <= (st_q == RTCSP_M_IDLE) & ~take;
      rsp_valid <= rv_q;
      if (rv_q) begin
        rsp_data <= sh_q;
        rsp_ack  <= ack_q;
      end
    end
  end

  assign bus.scl_o    = scl_q;
  assign bus.scl_oe   = ~scl_q;
  assign bus.sda_m_o  = sda_q;
  assign bus.sda_m_oe = ~sda_q;
endmodule

// >>> test/rtcsp_bus_monitor.sv
// Protocol checker for the two-wire bus
`timescale 1ns/1ps
module rtcsp_bus_monitor
  import rtcsp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe,
  // Supply fail
  input wire logic supply_fail
);
  // --------
  // Tracking
  // --------
  logic       scl_q, sda_q, first_q, match_q, rw_q, nack_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  wire        rise = scl & ~scl_q;
  wire        strt = scl & scl_q & sda_q & ~sda;
  wire        ackr = rise & (bit_q == BIT_ACK);
  always_ff @(posedge sys_clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn || strt) begin
      bit_q   <= 4'h0;
      first_q <= 1'h1;
      nack_q  <= 1'h0;
    end else if (ackr) begin
      bit_q   <= 4'h0;
      first_q <= 1'h0;
      nack_q  <= sda;
    end else if (rise) begin
      bit_q <= bit_q + 4'h1;
      sh_q  <= {sh_q[6:0], sda};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (ackr && first_q) begin
      match_q <= (sh_q[7:1] == SLAVE_ADDR);
      rw_q    <= sh_q[0];
    end
  end
  // ----------
  // Assertions
  // ----------
  sequence hold_s;
    (sda_s_oe && !sda)[*8];
  endsequence
  sequence quiet_s;
    supply_fail[*4];
  endsequence
  addr_ack_a: assert property (@(posedge sys_clk) disable iff (!rstn || supply_fail)
    ackr && first_q && sh_q[7:1] == SLAVE_ADDR |-> sda_s_oe) else $error("address not acknowledged");
  wrong_addr_a: assert property (@(posedge sys_clk) disable iff (!rstn || supply_fail)
    ackr && first_q && sh_q[7:1] != SLAVE_ADDR |-> !sda_s_oe) else $error("foreign address acknowledged");
  write_ack_a: assert property (@(posedge sys_clk) disable iff (!rstn || supply_fail)
    ackr && !first_q && match_q && !rw_q |-> sda_s_oe) else $error("written byte not acknowledged");
  ack_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn || supply_fail)
    ackr && sda_s_oe |-> hold_s) else $error("acknowledge not held low");
  nack_free_a: assert property (@(posedge sys_clk) disable iff (!rstn || supply_fail)
    nack_q |-> !sda_s_oe) else $error("data line driven after no-acknowledge");
  sda_stable_a: assert property (@(posedge sys_clk) disable iff (!rstn || supply_fail)
    scl && $past(scl) |-> $stable(sda_s_oe)) else $error("data changed while clock high");
  fail_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    quiet_s |-> !sda_s_oe) else $error("bus driven during supply fail");
  scl_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(scl) |-> scl[*8]) else $error("clock pulse too short");
endmodule

// >>> test/test_rtc_two_wire_slave_port.sv
// Bench joining master and slave ends over the two-wire bus
`timescale 1ns/1ps
module test_rtc_two_wire_slave_port;
  import rtcsp_pkg::*;
  // -------
  // Signals
  // -------
  logic        sys_clk, rstn, supply_fail, time_load_en, map_we;
  logic        cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack;
  logic        cmd_ready, rsp_ack, rsp_valid;
  logic [7:0]  cmd_data, rsp_data, map_wdata, d1, d2;
  logic [6:0]  bad;
  logic [4:0]  map_addr;
  logic [63:0] time_now, time_load, last_load;
  logic [12:0] wq[$];
  int          fails, samples_checked, loads;
  wire  [7:0]  map_rdata = {3'h0, map_addr} ^ 8'h5A;
  rtcsp_bus_if bus_if ();
  rtcsp_slave i_rtcsp_slave (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_if.device), .supply_fail(supply_fail),
    .time_now(time_now), .time_load(time_load), .time_load_en(time_load_en), .map_addr(map_addr),
    .map_wdata(map_wdata), .map_we(map_we), .map_rdata(map_rdata));
  rtcsp_master i_rtcsp_master (.sys_clk(sys_clk), .rstn(rstn), .bus(bus_if.host), .cmd_valid(cmd_valid),
    .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_nack(cmd_nack),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .rsp_valid(rsp_valid));
  rtcsp_bus_monitor i_mon (.sys_clk(sys_clk), .rstn(rstn), .scl(bus_if.scl), .sda(bus_if.sda),
    .sda_s_oe(bus_if.sda_s_oe), .supply_fail(supply_fail));
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (map_we === 1'h1) begin
      wq.push_back({map_addr, map_wdata});
    end
    if (time_load_en === 1'h1) begin
      loads++;
      last_load = time_load;
    end
  end
  // -----
  // Tasks
  // -----
  function automatic logic [7:0] map_val(input logic [4:0] a);
    return {3'h0, a} ^ 8'h5A;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check_flag(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_word(input string n, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // Flags: start, stop, read, nack
  task automatic xfer(input logic [3:0] f, input logic [7:0] d);
    int n;
    {cmd_start, cmd_stop, cmd_read, cmd_nack} <= f;
    cmd_data  <= d;
    cmd_valid <= 1'h1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready !== 1'h1 && n < 9000);
    cmd_valid <= 1'h0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp_valid !== 1'h1 && n < 9000);
    if (n >= 9000) begin
      fails++;
      summarize();
    end
  endtask
  // --------
  // Sequence
  // --------
  initial begin
    rstn = 1'h0;
    supply_fail = 1'h0;
    cmd_valid = 1'h0;
    {cmd_start, cmd_stop, cmd_read, cmd_nack} = 4'h0;
    cmd_data = 8'h00;
    fails = 0;
    samples_checked = 0;
    loads = 0;
    void'($urandom(9500));
    time_now = {$urandom, $urandom};
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    bad = 7'($urandom);
    if (bad == SLAVE_ADDR) begin
      bad = ~bad;
    end
    repeat (3) @(posedge sys_clk);
    rstn <= 1'h1;
    // Write across the end of the map
    xfer(4'h8, 8'hD0);
    check_flag("addr ack", 1'h1, rsp_ack);
    xfer(4'h0, 8'h1F);
    check_flag("ptr ack", 1'h1, rsp_ack);
    xfer(4'h0, d1);
    check_flag("data ack", 1'h1, rsp_ack);
    xfer(4'h4, d2);
    check_flag("last ack", 1'h1, rsp_ack);
    for (int i = 0; i < 100 && loads == 0; i++) @(posedge sys_clk);
    check_word("loads", 64'h1, 64'(loads));
    check_word("time load", {time_now[63:8], d2}, last_load);
    check_word("map writes", 64'h1, 64'(wq.size()));
    check_word("map write", {51'h0, 5'h1F, d1}, 64'(wq[0]));
    wq.delete();
    $display("test write done");
    // Read over the wrap with repeated start
    xfer(4'h8, 8'hD0);
    xfer(4'h0, 8'h1F);
    xfer(4'h8, 8'hD1);
    check_flag("read addr ack", 1'h1, rsp_ack);
    xfer(4'h2, 8'h00);
    check_word("read last", 64'(map_val(5'h1F)), 64'(rsp_data));
    xfer(4'h7, 8'h00);
    check_word("read wrap", 64'(time_now[7:0]), 64'(rsp_data));
    $display("test read done");
    // Foreign address
    xfer(4'hC, {bad, 1'h0});
    check_flag("foreign ack", 1'h0, rsp_ack);
    $display("test foreign done");
    // Supply fail in mid-write
    xfer(4'h8, 8'hD0);
    xfer(4'h0, 8'h0A);
    supply_fail <= 1'h1;
    xfer(4'h4, d1);
    check_flag("fail ack", 1'h0, rsp_ack);
    supply_fail <= 1'h0;
    repeat (8) @(posedge sys_clk);
    xfer(4'h8, 8'hD1);
    xfer(4'h7, 8'h00);
    check_word("read after fail", 64'(time_now[7:0]), 64'(rsp_data));
    check_word("fail writes", 64'h0, 64'(wq.size()));
    $display("test fail done");
    summarize();
  end
endmodule
